/* File: hdl/ctpair_top.sv */
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: Cascade bit selects two 16-bit or one 32-bit
// RULE2: Cascaded: high timer control bits are ignored
// RULE3: Cascaded: low clock/gate, high interrupt flag
// RULE4: Cascaded count: high word msw, low lsw
// RULE5: Cascaded period match uses both period words
// RULE6: Dual 16-bit, 32-bit timer, 32-bit counter
// RULE7: Each 16-bit timer synchronous timer or counter
// RULE8: Converter trigger from cascade or high only
// RULE9: Two-bit prescale; low prescale drives cascade
// RULE10: Clock source select and gate enable bits
// RULE11: Timer counts only while run bit set
// RULE12: Software sets run bit after all setup
// RULE13: Timers keep running in low-power states
// RULE14: Match clears count next edge, sets flag
// RULE15: Cascaded high word increments on low rollover
module ctpair_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [ctpair_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ctpair_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ctpair_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [ctpair_pkg::NUM_TIMERS-1:0] external_timer_clock_input,
    input wire logic [ctpair_pkg::NUM_TIMERS-1:0] gate_pin,
    output logic low_timer_irq,
    output logic high_timer_irq,
    output logic [ctpair_pkg::PRIO_W-1:0] low_timer_irq_priority,
    output logic [ctpair_pkg::PRIO_W-1:0] high_timer_irq_priority,
    output logic adc_start_event,
    output logic low_match_event,
    output logic high_match_event
);
    import ctpair_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [DATA_W-1:0] low_timer_control;
    logic [DATA_W-1:0] high_timer_control;
    logic [DATA_W-1:0] low_count_word;
    logic [DATA_W-1:0] high_count_word;
    logic [DATA_W-1:0] low_period_word;
    logic [DATA_W-1:0] high_period_word;
    logic [DATA_W-1:0] irq_control;
    logic [NUM_TIMERS-1:0] irq_flags;

    logic [DATA_W-1:0] next_low_count;
    logic [DATA_W-1:0] next_high_count;
    logic [NUM_TIMERS-1:0] next_irq_flags;
    logic [NUM_TIMERS-1:0] flag_clear;
    logic [NUM_TIMERS-1:0] flag_set;

    logic cascade_select;
    logic low_hit;
    logic high_hit;
    logic match_low;
    logic match_high;

    logic wr_low_ctrl;
    logic wr_high_ctrl;
    logic wr_low_count;
    logic wr_high_count;

    // ----------------------------------------
    // Pin synchronisers and edges
    // ----------------------------------------
    logic [SYNC_W-1:0] pins_sync;
    logic [SYNC_W-1:0] pins_prev;
    logic [NUM_TIMERS-1:0] ext_rise;
    logic [NUM_TIMERS-1:0] gate_level;
    logic [NUM_TIMERS-1:0] gate_fall;

    ctpair_sync ctpair_sync_inst (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in({gate_pin, external_timer_clock_input}),
        .sync_out(pins_sync)
    );

    // Edges are taken from the second stage only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pins_prev <= '0;
        end else begin
            pins_prev <= pins_sync;
        end
    end

    always_comb begin
        ext_rise = pins_sync[NUM_TIMERS-1:0] & ~pins_prev[NUM_TIMERS-1:0];
        gate_level = pins_sync[SYNC_W-1:NUM_TIMERS];
        gate_fall = pins_prev[SYNC_W-1:NUM_TIMERS] & ~pins_sync[SYNC_W-1:NUM_TIMERS];
    end

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    always_comb begin
        wr_low_ctrl = reg_wr && (reg_addr == ADDR_LOW_CTRL);
        wr_high_ctrl = reg_wr && (reg_addr == ADDR_HIGH_CTRL);
        wr_low_count = reg_wr && (reg_addr == ADDR_LOW_COUNT);
        wr_high_count = reg_wr && (reg_addr == ADDR_HIGH_COUNT);
        flag_clear = (reg_wr && (reg_addr == ADDR_IRQ_STAT)) ?
            reg_wdata[NUM_TIMERS-1:0] : '0;
    end

    assign cascade_select = low_timer_control[BIT_CASCADE]; // RULE1

    // ----------------------------------------
    // Prescalers, one per timer
    // ----------------------------------------
    logic [DATA_W-1:0] ctl_arr [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] restart_arr;
    logic [NUM_TIMERS-1:0] run_arr;
    logic [NUM_TIMERS-1:0] tick;

    assign ctl_arr[0] = low_timer_control;
    assign ctl_arr[1] = high_timer_control;
    assign restart_arr = {wr_high_ctrl, wr_low_ctrl};
    // High prescaler idles in cascade; its control is not looked at
    assign run_arr[0] = low_timer_control[BIT_RUN]; // RULE11
    assign run_arr[1] = high_timer_control[BIT_RUN] & ~cascade_select; // RULE2

    // One prescaler per timer keeps the ratios independent
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
            ctpair_tick_if tk ();
            assign tk.run = run_arr[gi];
            assign tk.ratio = ctl_arr[gi][BIT_PS_HI:BIT_PS_LO]; // RULE9
            assign tk.csel = ctl_arr[gi][BIT_CSEL]; // RULE10
            assign tk.gate_en = ctl_arr[gi][BIT_GATE]; // RULE10
            assign tk.ext_edge = ext_rise[gi]; // RULE7
            assign tk.gate_lvl = gate_level[gi];
            assign tick[gi] = tk.tick;

            ctpair_presc ctpair_presc_inst (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .restart(restart_arr[gi]),
                .tk(tk)
            );
        end
    endgenerate

    // ----------------------------------------
    // Count and match
    // ----------------------------------------
    assign low_hit = (low_count_word == low_period_word);
    assign high_hit = (high_count_word == high_period_word);

    // No low-power input exists; counting never pauses for it
    always_comb begin // RULE13
        next_low_count = low_count_word;
        next_high_count = high_count_word;
        match_low = 1'b0;
        match_high = 1'b0;
        if (cascade_select) begin // RULE6
            if (tick[0]) begin // RULE3
                if (low_hit && high_hit) begin // RULE5
                    next_low_count = COUNT_RST; // RULE14
                    next_high_count = COUNT_RST;
                    match_high = 1'b1;
                end else begin
                    next_low_count = low_count_word + COUNT_STEP; // RULE4
                    if (low_count_word == COUNT_ALL_ONES) begin
                        next_high_count = high_count_word + COUNT_STEP; // RULE15
                    end
                end
            end
        end else begin
            if (tick[0]) begin
                if (low_hit) begin
                    next_low_count = COUNT_RST; // RULE14
                    match_low = 1'b1;
                end else begin
                    next_low_count = low_count_word + COUNT_STEP;
                end
            end
            if (tick[1]) begin
                if (high_hit) begin
                    next_high_count = COUNT_RST; // RULE14
                    match_high = 1'b1;
                end else begin
                    next_high_count = high_count_word + COUNT_STEP;
                end
            end
        end
        // Software load beats a count on the same edge
        if (wr_low_count) begin
            next_low_count = reg_wdata;
        end
        if (wr_high_count) begin
            next_high_count = reg_wdata;
        end
    end

    // Loads and counts share one next-value path
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            low_count_word <= COUNT_RST;
        end else begin
            low_count_word <= next_low_count;
        end
    end

    // High word is also the cascaded msw
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            high_count_word <= COUNT_RST;
        end else begin
            high_count_word <= next_high_count;
        end
    end

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    logic [NUM_TIMERS-1:0] gate_end;

    // Gated accumulation ends on the falling gate edge
    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            gate_end[i] = gate_fall[i] & run_arr[i]
                & ctl_arr[i][BIT_GATE] & ~ctl_arr[i][BIT_CSEL];
        end
        flag_set[0] = match_low | (gate_end[0] & ~cascade_select);
        flag_set[1] = match_high | (cascade_select ? gate_end[0] : gate_end[1]); // RULE3
        // Set wins over a clear in the same cycle
        next_irq_flags = (irq_flags & ~flag_clear) | flag_set;
    end

    // Flags persist until written with ones
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_flags <= '0;
        end else begin
            irq_flags <= next_irq_flags; // RULE14
        end
    end

    // ----------------------------------------
    // Event and interrupt outputs
    // ----------------------------------------
    // Levels follow the next flag so they rise with the event
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            low_timer_irq <= 1'b0;
            high_timer_irq <= 1'b0;
        end else begin
            low_timer_irq <= next_irq_flags[0] & irq_control[BIT_IRQ_EN_LO];
            high_timer_irq <= next_irq_flags[1] & irq_control[BIT_IRQ_EN_HI]; // RULE3
        end
    end

    // Priorities are plain copies for the interrupt controller
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            low_timer_irq_priority <= '0;
            high_timer_irq_priority <= '0;
        end else begin
            low_timer_irq_priority <= irq_control[BIT_PRIO_LO_LSB +: PRIO_W];
            high_timer_irq_priority <= irq_control[BIT_PRIO_HI_LSB +: PRIO_W];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            adc_start_event <= 1'b0;
            low_match_event <= 1'b0;
            high_match_event <= 1'b0;
        end else begin
            // Low timer alone never starts the converter
            adc_start_event <= match_high; // RULE8
            low_match_event <= match_low;
            high_match_event <= match_high;
        end
    end

    // ----------------------------------------
    // Control and period registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            low_timer_control <= CTRL_RST;
            high_timer_control <= CTRL_RST;
            low_period_word <= PERIOD_RST;
            high_period_word <= PERIOD_RST;
            irq_control <= CTRL_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_LOW_CTRL: begin
                    low_timer_control <= reg_wdata & LOW_CTRL_MASK; // RULE1
                end
                ADDR_HIGH_CTRL: begin
                    high_timer_control <= reg_wdata & HIGH_CTRL_MASK;
                end
                ADDR_LOW_PERIOD: begin
                    low_period_word <= reg_wdata;
                end
                ADDR_HIGH_PERIOD: begin
                    high_period_word <= reg_wdata;
                end
                ADDR_IRQ_CTRL: begin
                    irq_control <= reg_wdata & IRQ_CTRL_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_LOW_CTRL: reg_rdata <= low_timer_control;
                ADDR_HIGH_CTRL: reg_rdata <= high_timer_control;
                ADDR_LOW_COUNT: reg_rdata <= low_count_word; // RULE4
                ADDR_HIGH_COUNT: reg_rdata <= high_count_word; // RULE4
                ADDR_LOW_PERIOD: reg_rdata <= low_period_word;
                ADDR_HIGH_PERIOD: reg_rdata <= high_period_word;
                ADDR_IRQ_STAT: reg_rdata <= {{(DATA_W-NUM_TIMERS){1'b0}}, irq_flags};
                ADDR_IRQ_CTRL: reg_rdata <= irq_control;
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

/* File: hdl/ctpair_pkg.sv */
package ctpair_pkg;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;

    localparam logic [ADDR_W-1:0] ADDR_LOW_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_HIGH_CTRL = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_LOW_COUNT = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_HIGH_COUNT = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_LOW_PERIOD = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_HIGH_PERIOD = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL = 3'h7;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int BIT_RUN = 15;
    localparam int BIT_GATE = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_CASCADE = 3;
    localparam int BIT_CSEL = 1;
    localparam logic [DATA_W-1:0] LOW_CTRL_MASK = 16'h807A;
    localparam logic [DATA_W-1:0] HIGH_CTRL_MASK = 16'h8072;

    localparam int BIT_IRQ_EN_LO = 0;
    localparam int BIT_IRQ_EN_HI = 1;
    localparam int BIT_PRIO_HI_LSB = 4;
    localparam int BIT_PRIO_LO_LSB = 8;
    localparam int PRIO_W = 3;
    localparam logic [DATA_W-1:0] IRQ_CTRL_MASK = 16'h0773;

    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [DATA_W-1:0] PERIOD_RST = 16'hFFFF;
    localparam logic [DATA_W-1:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [DATA_W-1:0] COUNT_STEP = 16'h0001;

    localparam int PS_W = 8;
    localparam logic [PS_W-1:0] PS_STEP = 8'h01;
    localparam logic [PS_W-1:0] PS_LIMIT [4] = '{8'h00, 8'h07, 8'h3F, 8'hFF};

    localparam int NUM_TIMERS = 2;
    localparam int SYNC_W = 4;

endpackage

/* File: hdl/ctpair_tick_if.sv */
`timescale 1ns/100ps
interface ctpair_tick_if;
    logic run;
    logic [1:0] ratio;
    logic csel;
    logic ext_edge;
    logic gate_en;
    logic gate_lvl;
    logic tick;

    modport presc (
        input run,
        input ratio,
        input csel,
        input ext_edge,
        input gate_en,
        input gate_lvl,
        output tick
    );

    modport core (
        output run,
        output ratio,
        output csel,
        output ext_edge,
        output gate_en,
        output gate_lvl,
        input tick
    );
endinterface

/* File: hdl/ctpair_sync.sv */
`timescale 1ns/100ps
module ctpair_sync
    import ctpair_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [ctpair_pkg::SYNC_W-1:0] async_in,
    output logic [ctpair_pkg::SYNC_W-1:0] sync_out
);
    logic [SYNC_W-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

/* File: hdl/ctpair_presc.sv */
`timescale 1ns/100ps
module ctpair_presc
    import ctpair_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic restart,
    ctpair_tick_if.presc tk
);
    logic [PS_W-1:0] div;
    logic src;

    // Internal source counts every cycle, or only gate-high cycles when gating is on; only synchronous counting exists
    always_comb begin
        src = (tk.csel ? tk.ext_edge : 1'b1)
            & (~tk.gate_en | tk.csel | tk.gate_lvl)
            & tk.run;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            div <= '0;
            tk.tick <= 1'b0;
        end else if (restart || !tk.run) begin
            div <= '0;
            tk.tick <= 1'b0;
        end else begin
            tk.tick <= 1'b0;
            if (src) begin
                if (div >= PS_LIMIT[tk.ratio]) begin
                    div <= '0;
                    tk.tick <= 1'b1;
                end else begin
                    div <= div + PS_STEP;
                end
            end
        end
    end
endmodule

/* File: tb/ctpair_checker.sv */
`timescale 1ns/100ps
module ctpair_checker
    import ctpair_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [ctpair_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ctpair_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ctpair_pkg::DATA_W-1:0] reg_rdata,
    input wire logic low_timer_irq,
    input wire logic high_timer_irq,
    input wire logic [ctpair_pkg::PRIO_W-1:0] low_timer_irq_priority,
    input wire logic adc_start_event,
    input wire logic low_match_event,
    input wire logic high_match_event
);
    // ----------------------------------------
    // Shadow of software setup
    // ----------------------------------------
    logic [15:0] lc, hc, lp, ic;
    logic [2:0] age;
    // Age lets pending pulses drain before a setting is trusted
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lc <= CTRL_RST;
            hc <= CTRL_RST;
            lp <= PERIOD_RST;
            ic <= 16'h0000;
            age <= 3'h7;
        end else if (reg_wr) begin
            age <= 3'h0;
            case (reg_addr)
                ADDR_LOW_CTRL: lc <= reg_wdata;
                ADDR_HIGH_CTRL: hc <= reg_wdata;
                ADDR_LOW_PERIOD: lp <= reg_wdata;
                ADDR_IRQ_CTRL: ic <= reg_wdata;
                default: ;
            endcase
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_low_ctrl_readback: assert property (reg_rd && reg_addr == ADDR_LOW_CTRL |=>
        reg_rdata == (lc & LOW_CTRL_MASK)) else $error("low control readback wrong");
    a_high_ctrl_readback: assert property (reg_rd && reg_addr == ADDR_HIGH_CTRL |=>
        reg_rdata == (hc & HIGH_CTRL_MASK)) else $error("high control readback wrong");
    a_period_readback: assert property (reg_rd && reg_addr == ADDR_LOW_PERIOD |=>
        reg_rdata == lp) else $error("low period readback wrong");
    a_prio_copy: assert property (age >= 3'h3 |->
        low_timer_irq_priority == ic[10:8]) else $error("low priority not copied");
    a_low_irq_mask: assert property (age >= 3'h3 && !ic[0] |->
        !low_timer_irq) else $error("low irq while disabled");
    a_high_irq_mask: assert property (age >= 3'h3 && !ic[1] |->
        !high_timer_irq) else $error("high irq while disabled");
    a_adc_high_only: assert property (age >= 3'h3 && !lc[3] && adc_start_event |->
        high_match_event) else $error("converter event without high match");
    a_low_stopped: assert property (age >= 3'h3 && !lc[15] |->
        !low_match_event) else $error("low match while stopped");
    a_high_stopped: assert property (age >= 3'h3 && !lc[3] && !hc[15] |->
        !high_match_event) else $error("high match while stopped");
    a_cascade_ignores: assert property (age >= 3'h3 && lc[3] && !lc[15] |->
        !high_match_event && !adc_start_event) else $error("high control used in cascade");
endmodule

bind ctpair_top ctpair_checker ctpair_checker_inst (.sys_clk(sys_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .low_timer_irq(low_timer_irq), .high_timer_irq(high_timer_irq),
    .low_timer_irq_priority(low_timer_irq_priority), .adc_start_event(adc_start_event),
    .low_match_event(low_match_event), .high_match_event(high_match_event));

/* File: tb/ctpair_top_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module ctpair_top_tb;
    import ctpair_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] ext_clk = 2'h0;
    logic [1:0] gate = 2'h0;
    logic [15:0] reg_rdata, rv;
    logic low_timer_irq, high_timer_irq, adc_start_event, low_match_event, high_match_event;
    logic [2:0] low_prio, high_prio;
    int n_checks = 0;
    int bad_count = 0;
    int adc_seen = 0;
    int n;

    ctpair_top ctpair_top_inst (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_timer_clock_input(ext_clk), .gate_pin(gate), .low_timer_irq(low_timer_irq),
        .high_timer_irq(high_timer_irq), .low_timer_irq_priority(low_prio),
        .high_timer_irq_priority(high_prio), .adc_start_event(adc_start_event),
        .low_match_event(low_match_event), .high_match_event(high_match_event));

    // ----------------------------------------
    // Clock, monitor, watchdog
    // ----------------------------------------
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        if (adc_start_event === 1'b1) adc_seen++;
    end
    // Whole run is under two thousand cycles; ten times that is a hang
    initial begin
        #200000;
        bad_count++;
        $display("Error at %0t: got %h expected %h", $time, 0, 1);
        finish_test;
    end

    // ----------------------------------------
    // Bus and event helpers
    // ----------------------------------------
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge sys_clk);
    endtask
    function automatic logic ev(input int sel);
        case (sel)
            0: return low_match_event;
            1: return high_match_event;
            default: return adc_start_event;
        endcase
    endfunction
    task automatic wait_ev(input int sel, output int k);
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (ev(sel) !== 1'b1 && k < 2000);
        if (k >= 2000) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, 0, 1);
        end
    endtask
    task automatic gap(input int sel, output int k);
        wait_ev(sel, k);
        wait_ev(sel, k);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        logic [15:0] exp_rst [8];
        exp_rst = '{CTRL_RST, CTRL_RST, COUNT_RST, COUNT_RST, PERIOD_RST, PERIOD_RST,
            16'h0000, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), rv);
            `CHK(rv, exp_rst[i])
        end
        wr(ADDR_LOW_CTRL, 16'h7FFF);
        wr(ADDR_HIGH_CTRL, 16'h7FFF);
        rd(ADDR_LOW_CTRL, rv);
        `CHK(rv, 16'h007A)
        rd(ADDR_HIGH_CTRL, rv);
        `CHK(rv, 16'h0072)
        wr(ADDR_LOW_CTRL, 16'h0000);
        wr(ADDR_HIGH_CTRL, 16'h0000);
        $display("test reset done");
    endtask

    task automatic test_low16();
        wr(ADDR_IRQ_CTRL, 16'h0501);
        wr(ADDR_LOW_PERIOD, 16'h0004);
        adc_seen = 0;
        wr(ADDR_LOW_CTRL, 16'h8000);
        gap(0, n);
        `CHK(n, 5)
        `CHK(low_timer_irq, 1'b1)
        `CHK(low_prio, 3'h5)
        wr(ADDR_LOW_CTRL, 16'h0000);
        `CHK(adc_seen, 0)
        repeat (3) @(posedge sys_clk);
        wr(ADDR_IRQ_STAT, 16'h0001);
        rd(ADDR_IRQ_STAT, rv);
        `CHK(rv, 16'h0000)
        `CHK(low_timer_irq, 1'b0)
        $display("test low16 done");
    endtask

    task automatic test_presc();
        int ratio [4] = '{1, 8, 64, 256};
        wr(ADDR_LOW_PERIOD, 16'h0001);
        for (int ps = 0; ps < 4; ps++) begin
            wr(ADDR_LOW_CTRL, 16'h8000 | (16'(ps) << 4));
            gap(0, n);
            `CHK(n, 2 * ratio[ps])
        end
        wr(ADDR_LOW_CTRL, 16'h0000);
        wr(ADDR_IRQ_STAT, 16'h0003);
        $display("test prescale done");
    endtask

    task automatic test_high16();
        wr(ADDR_IRQ_CTRL, 16'h0052);
        wr(ADDR_HIGH_PERIOD, 16'h0002);
        adc_seen = 0;
        wr(ADDR_HIGH_CTRL, 16'h8000);
        gap(1, n);
        `CHK(n, 3)
        `CHK(high_timer_irq, 1'b1)
        wr(ADDR_HIGH_CTRL, 16'h0000);
        `CHK(adc_seen != 0, 1'b1)
        `CHK(high_prio, 3'h5)
        repeat (3) @(posedge sys_clk);
        wr(ADDR_IRQ_STAT, 16'h0003);
        $display("test high16 done");
    endtask

    task automatic load32(input logic [15:0] ph, pl, ch, cl);
        wr(ADDR_HIGH_PERIOD, ph);
        wr(ADDR_LOW_PERIOD, pl);
        wr(ADDR_HIGH_COUNT, ch);
        wr(ADDR_LOW_COUNT, cl);
    endtask

    task automatic test_cascade();
        wr(ADDR_LOW_CTRL, 16'h0008);
        // Slow high setup must have no effect while cascaded
        wr(ADDR_HIGH_CTRL, 16'h8030);
        load32(16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFE);
        wr(ADDR_LOW_CTRL, 16'h8008);
        repeat (4) @(posedge sys_clk);
        wr(ADDR_LOW_CTRL, 16'h0008);
        rd(ADDR_HIGH_COUNT, rv);
        `CHK(rv, 16'h0001)
        rd(ADDR_LOW_COUNT, rv);
        `CHK(rv < 16'h0008, 1'b1)
        load32(16'h0001, 16'h0002, 16'h0000, 16'hFFFE);
        wr(ADDR_LOW_CTRL, 16'h8008);
        wait_ev(2, n);
        `CHK(n < 20, 1'b1)
        wr(ADDR_LOW_CTRL, 16'h0008);
        rd(ADDR_IRQ_STAT, rv);
        `CHK(rv, 16'h0002)
        `CHK(high_timer_irq, 1'b1)
        wr(ADDR_IRQ_STAT, 16'h0003);
        wr(ADDR_LOW_CTRL, 16'h0000);
        wr(ADDR_HIGH_CTRL, 16'h0000);
        $display("test cascade done");
    endtask

    task automatic test_ext_gate();
        load32(16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000);
        wr(ADDR_LOW_CTRL, 16'h8002);
        wr(ADDR_HIGH_CTRL, 16'h8002);
        repeat (5) begin
            ext_clk <= 2'h3;
            repeat (3) @(posedge sys_clk);
            ext_clk <= 2'h0;
            repeat (3) @(posedge sys_clk);
        end
        repeat (5) @(posedge sys_clk);
        rd(ADDR_LOW_COUNT, rv);
        `CHK(rv, 16'h0005)
        rd(ADDR_HIGH_COUNT, rv);
        `CHK(rv, 16'h0005)
        wr(ADDR_LOW_COUNT, 16'h0000);
        wr(ADDR_LOW_CTRL, 16'h8040);
        wr(ADDR_HIGH_CTRL, 16'h8040);
        repeat (10) @(posedge sys_clk);
        rd(ADDR_LOW_COUNT, rv);
        `CHK(rv, 16'h0000)
        gate <= 2'h3;
        repeat (10) @(posedge sys_clk);
        gate <= 2'h0;
        repeat (6) @(posedge sys_clk);
        wr(ADDR_LOW_CTRL, 16'h0000);
        wr(ADDR_HIGH_CTRL, 16'h0000);
        rd(ADDR_IRQ_STAT, rv);
        `CHK(rv, 16'h0003)
        rd(ADDR_LOW_COUNT, rv);
        `CHK(rv != 16'h0000, 1'b1)
        $display("test ext and gate done");
    endtask

    // ----------------------------------------
    // Verdict and main sequence
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        test_reset();
        test_low16();
        test_presc();
        test_high16();
        test_cascade();
        test_ext_gate();
        finish_test;
    end
endmodule
